// [design/rrl_top.v]
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "rrl_consts.vh"
module rrl_top #(
  parameter integer NCH = 16,
  parameter integer CW  = 16
) (
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [7:0]        wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  input  wire [NCH*CW-1:0] vco_cnt_i,
  output reg  [NCH-1:0]    lock_o,
  output reg  [NCH-1:0]    pgen_en_o,
  output reg  [NCH-1:0]    pchk_en_o
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [3:0]     lim_r;
  reg  [3:0]     refdiv_r;
  reg  [7:0]     ch_r [0:NCH-1];
  reg  [10:0]    cnt_r;
  reg            tick_r;
  reg  [NCH-1:0] grant_r;
  wire [NCH-1:0] req;
  wire [NCH-1:0] lock;
  wire [NCH-1:0] cdr_rst;
  wire [CW-1:0]  tol = 16'd8;
  wire           acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire           wr0 = acc & wb_we_i & wb_sel_i[0];
  wire [3:0]     chi = wb_adr_i[5:2];
  wire           ch_hit = wb_adr_i[7:6] == 2'b01;
  integer        i;
  integer        j;
  reg  [4:0]     lim_eff;
  reg  [4:0]     nact;
  reg  [NCH-1:0] gnt_nxt;
  // ----------------------------------------------------------------
  // Count window
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= 11'h000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= cnt_r == `RRL_CNT_CYC - 1;
      cnt_r  <= (cnt_r == `RRL_CNT_CYC - 1) ? 11'h000 : cnt_r + 11'h001;
    end
  end
  // ----------------------------------------------------------------
  // Lock slot arbiter
  // ----------------------------------------------------------------
  always @* begin
    // A limit of 0 acts as 1; the cap never rises above the default of 8
    lim_eff = (lim_r == 4'h0) ? 5'h01 :
              (lim_r > `RRL_SH_LIM_RST) ? {1'b0, `RRL_SH_LIM_RST} :
              {1'b0, lim_r};
    nact = 5'h00;
    gnt_nxt = grant_r & req;
    for (i = 0; i < NCH; i = i + 1)
      if (gnt_nxt[i]) nact = nact + 5'h01;
    // Lowest index wins a freed slot
    for (i = 0; i < NCH; i = i + 1)
      if (req[i] && !gnt_nxt[i] && nact < lim_eff) begin
        gnt_nxt[i] = 1'b1;
        nact = nact + 5'h01;
      end
  end
  // ----------------------------------------------------------------
  // Wishbone slave and channel state
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      lim_r     <= `RRL_SH_LIM_RST;
      refdiv_r  <= `RRL_SH_REFDIV_RST;
      grant_r   <= {NCH{1'b0}};
      lock_o    <= {NCH{1'b0}};
      pgen_en_o <= {NCH{1'b0}};
      pchk_en_o <= {NCH{1'b0}};
      for (j = 0; j < NCH; j = j + 1) ch_r[j] <= `RRL_CH_RST_VAL;
    end else begin
      grant_r  <= gnt_nxt;
      lock_o   <= lock;
      wb_ack_o <= acc;
      wb_dat_o <= 32'h0000_0000;
      for (j = 0; j < NCH; j = j + 1) begin
        pgen_en_o[j] <= ch_r[j][`RRL_CH_PGEN_BIT];
        pchk_en_o[j] <= ch_r[j][`RRL_CH_PCHK_BIT] &
                        ~ch_r[j][`RRL_CH_PGEN_BIT];
      end
      if (acc && !wb_we_i) begin
        if (wb_adr_i == `RRL_ADR_SHARED)
          wb_dat_o <= {20'h00000, refdiv_r, 4'h0, lim_r};
        else if (wb_adr_i == `RRL_ADR_STATUS)
          wb_dat_o <= {grant_r, lock};
        else if (ch_hit)
          wb_dat_o <= {24'h000000, ch_r[chi]};
      end
      if (wr0 && wb_adr_i == `RRL_ADR_SHARED)
        lim_r <= wb_dat_i[`RRL_SH_LIM_LSB+3:`RRL_SH_LIM_LSB];
      if (acc && wb_we_i && wb_sel_i[1] && wb_adr_i == `RRL_ADR_SHARED)
        refdiv_r <= wb_dat_i[`RRL_SH_REFDIV_LSB+3:`RRL_SH_REFDIV_LSB];
      if (wr0 && ch_hit) begin
        ch_r[chi] <= wb_dat_i[7:0];
        // Generator wins if both asked for; the checker bit is dropped
        if (wb_dat_i[`RRL_CH_PGEN_BIT])
          ch_r[chi][`RRL_CH_PCHK_BIT] <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      assign cdr_rst[g] = ch_r[g][`RRL_CH_RST_BIT];
      rrl_lock_chan #(.CW(CW)) u_ch (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .cdr_rst_i (cdr_rst[g]),
        .rate_i    (ch_r[g][7:4]),
        .tick_i    (tick_r),
        .vco_cnt_i (vco_cnt_i[g*CW +: CW]),
        .tol_i     (tol),
        .grant_i   (grant_r[g]),
        .req_o     (req[g]),
        .lock_o    (lock[g]),
        .div1_o    (),
        .div2_o    ()
      );
    end
  endgenerate
endmodule // rrl_top
`default_nettype wire

// [design/rrl_consts.vh]
// Overview of operation
// - Lock sequencer caps concurrent acquiring channels; default 8, may be set to 1.
// - Per channel, pattern generator and sequence checker are never active together.
// - A channel locks only at its programmed rates and dividers.
// - Each channel uses its own rate code, independent of others.
// - Rate code field selects the rate set; 0x6 is 11.5 Gbps, divider 1.
// - Codes 0x7 and 0x8 use dividers 1, 2 and 4 in both groups.
// - Code 0x9 uses dividers 2, 4; code 0xA uses 1, 2, 4.
// - Code 0xB uses divider 8 in group one, divider 1 in group two.
// - Rate counting spans 1024 reference periods at 25 MHz, VCO divided by 32.
`ifndef RRL_CONSTS_VH
`define RRL_CONSTS_VH
// ----------------------------------------------------------------
// Register map (byte offsets, word aligned, byte address = offset)
// ----------------------------------------------------------------
`define RRL_ADR_SHARED  8'h00
`define RRL_ADR_STATUS  8'h04
`define RRL_ADR_CH_BASE 8'h40
// Shared register fields
`define RRL_SH_LIM_LSB  0
`define RRL_SH_REFDIV_LSB 8
`define RRL_SH_LIM_RST  4'h8
`define RRL_SH_REFDIV_RST 4'h0
// Channel register fields
`define RRL_CH_RST_BIT  0
`define RRL_CH_PGEN_BIT 1
`define RRL_CH_PCHK_BIT 2
`define RRL_CH_RATE_LSB 4
`define RRL_CH_RST_VAL  8'h01
// Rate codes
`define RRL_RATE_CUSTOM 4'h6
`define RRL_RATE_IL     4'h7
`define RRL_RATE_CPRI1  4'h8
`define RRL_RATE_CPRI2  4'h9
`define RRL_RATE_10G    4'ha
`define RRL_RATE_ETH    4'hb
// Divider masks: bit0=/1 bit1=/2 bit2=/4 bit3=/8
`define RRL_DIV_1       4'h1
`define RRL_DIV_124     4'h7
`define RRL_DIV_24      4'h6
`define RRL_DIV_8       4'h8
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RRL_REF_MHZ     25
`define RRL_CLK_MHZ     25
`define RRL_CNT_PERIODS 1024
`define RRL_CNT_CYC     ((`RRL_CNT_PERIODS*`RRL_CLK_MHZ)/`RRL_REF_MHZ)
`endif

// [design/rrl_lock_chan.v]
`timescale 1ns/100ps
`default_nettype none
`include "rrl_consts.vh"
module rrl_lock_chan #(
  parameter integer CW = 16
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire          cdr_rst_i,
  input  wire [3:0]    rate_i,
  input  wire          tick_i,
  input  wire [CW-1:0] vco_cnt_i,
  input  wire [CW-1:0] tol_i,
  input  wire          grant_i,
  output reg           req_o,
  output reg           lock_o,
  output reg  [3:0]    div1_o,
  output reg  [3:0]    div2_o
);
  // ----------------------------------------------------------------
  // Divider table
  // ----------------------------------------------------------------
  reg [3:0]    d1;
  reg [3:0]    d2;
  reg [CW-1:0] exp_cnt;
  reg          match;
  always @* begin
    d1 = 4'h0;
    d2 = 4'h0;
    exp_cnt = {CW{1'b0}};
    case (rate_i)
      `RRL_RATE_CUSTOM: begin
        d1 = `RRL_DIV_1; d2 = `RRL_DIV_1; exp_cnt = 16'd14720;
      end
      `RRL_RATE_IL, `RRL_RATE_CPRI1, `RRL_RATE_10G: begin
        d1 = `RRL_DIV_124; d2 = `RRL_DIV_124;
        exp_cnt = (rate_i == `RRL_RATE_IL) ? 16'd16000 :
                  (rate_i == `RRL_RATE_CPRI1) ? 16'd12583 : 16'd12800;
      end
      `RRL_RATE_CPRI2: begin
        d1 = `RRL_DIV_24; d2 = `RRL_DIV_24; exp_cnt = 16'd15729;
      end
      `RRL_RATE_ETH: begin
        d1 = `RRL_DIV_8; d2 = `RRL_DIV_1; exp_cnt = 16'd13200;
      end
      default: begin
        d1 = 4'h0; d2 = 4'h0; exp_cnt = {CW{1'b0}};
      end
    endcase
    // Count taken over 1024 ref periods of VCO/32, compared unscaled with exp_cnt
    // One spare bit so a count near full scale cannot wrap into a match
    match = (d1 != 4'h0) &&
            ({1'b0, vco_cnt_i} + {1'b0, tol_i} >= {1'b0, exp_cnt}) &&
            ({1'b0, vco_cnt_i} <= {1'b0, exp_cnt} + {1'b0, tol_i});
  end
  // Slot held only while acquiring; released once locked or reset
  always @(posedge clk_i) begin
    if (rst_i || cdr_rst_i) begin
      req_o  <= 1'b0;
      lock_o <= 1'b0;
      div1_o <= 4'h0;
      div2_o <= 4'h0;
    end else begin
      div1_o <= d1;
      div2_o <= d2;
      if (!lock_o) begin
        req_o <= ~(grant_i & tick_i & match);
        if (grant_i && tick_i && match) lock_o <= 1'b1;
      end else begin
        req_o <= 1'b0;
        if (tick_i && !match) lock_o <= 1'b0;
      end
    end
  end
endmodule // rrl_lock_chan
`default_nettype wire

// [dv/rrl_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module rrl_chk #(parameter integer NCH = 16) (
  input wire logic           clk_i,
  input wire logic           rst_i,
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic           wb_we_i,
  input wire logic           wb_ack_o,
  input wire logic [NCH-1:0] lock_o,
  input wire logic [NCH-1:0] pgen_en_o,
  input wire logic [NCH-1:0] pchk_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  AST_ACK_CAUSE: assert property (wb_ack_o
    |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
  AST_EXCL: assert property (!(|(pgen_en_o & pchk_en_o)))
    else $error("gen and check both on");
  AST_LIM: assert property ($countones(lock_o & ~$past(lock_o)) <= 8)
    else $error("too many locks at once");
  // After a lock rises, no further lock rises in the next 8 cycles
  AST_WIN: assert property (|(lock_o & ~$past(lock_o))
    |=> (!(|(lock_o & ~$past(lock_o))))[*8]) else $error("lock off window");
  AST_RST: assert property ($fell(rst_i)
    |-> lock_o == '0 && pgen_en_o == '0 && pchk_en_o == '0)
    else $error("reset state");
  AST_PG_CAUSE: assert property ($changed(pgen_en_o | pchk_en_o)
    |-> $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2))
    else $error("enable moved without write");
endmodule // rrl_chk
bind rrl_top rrl_chk #(.NCH(NCH)) rrl_chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .lock_o(lock_o), .pgen_en_o(pgen_en_o),
  .pchk_en_o(pchk_en_o));
`default_nettype wire

// [dv/rrl_host.sv]
`timescale 1ns/100ps
`default_nettype none
module rrl_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output var  logic        cyc_o,
  output var  logic        we_o,
  output var  logic [7:0]  adr_o,
  output var  logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0;
  end
  // Caller enters just after an edge; bus lines invert once released
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
    cyc_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = dat_i;
    cyc_o <= 1'b0;
    we_o <= ~w;
    adr_o <= ~a;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule // rrl_host
`default_nettype wire

// [dv/retimer_rate_lock_setup_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module retimer_rate_lock_setup_bench;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc, we, ack;
  logic [7:0]   adr;
  logic [31:0]  wdat, rdat, q;
  logic [255:0] vco = '0;
  logic [15:0]  lock, pgen, pchk;
  int           n_mismatch = 0;
  int           samples_checked = 0;
  rrl_top rrl_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .vco_cnt_i(vco),
    .lock_o(lock), .pgen_en_o(pgen), .pchk_en_o(pchk));
  rrl_host rrl_host_i (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .we_o(we), .adr_o(adr), .dat_o(wdat));
  initial forever #20 clk_i = ~clk_i;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    rrl_host_i.xfer(1'b1, a, d, q);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    rrl_host_i.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Bounded wait; a channel that never locks shows up in the compare
  task wait_lock(input logic [15:0] m);
    int i;
    i = 0;
    while ((lock & m) !== m && i < 3000) begin
      @(posedge clk_i);
      i++;
    end
    chk(lock & m, m);
  endtask
  task t_reg;
    rd(8'h00, 32'h8);
    rd(8'h44, 32'h1);
    rd(8'h3c, 32'h0);
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h1);
    $display("t_reg done");
  endtask
  task t_excl;
    wr(8'h40, 32'h7);
    repeat (3) @(posedge clk_i);
    chk({pgen[0], pchk[0]}, 2'b10);
    wr(8'h40, 32'h5);
    repeat (3) @(posedge clk_i);
    chk({pgen[0], pchk[0]}, 2'b01);
    $display("t_excl done");
  endtask
  task t_lock;
    vco[63:0] <= {16'd12800, 16'd12800, 16'd13200, 16'd12800};
    wr(8'h40, 32'ha1);
    wr(8'h44, 32'hb1);
    wr(8'h48, 32'h51);
    wr(8'h4c, 32'ha1);
    wr(8'h40, 32'ha0);
    wr(8'h44, 32'hb0);
    wait_lock(16'h0001);
    chk(lock, 16'h0001);
    wait_lock(16'h0003);
    wr(8'h48, 32'h50);
    repeat (2200) @(posedge clk_i);
    chk(lock, 16'h0003);
    rrl_host_i.xfer(1'b0, 8'h04, 32'h0, q);
    chk(q, 32'h0004_0003);
    $display("t_lock done");
  endtask
  // Enter CDR reset with the rate code, release it in a second write
  task cfg(input logic [7:0] a, input logic [3:0] c);
    wr(a, {24'h000000, c, 4'h1});
    wr(a, {24'h000000, c, 4'h0});
  endtask
  // Counts are rate/32 over 1024 periods of 25 MHz; +-8 is accepted
  task t_rates;
    vco[64 +: 112] <= {16'd12574, 16'd16009, 16'd16008, 16'd15729,
                       16'd12583, 16'd16000, 16'd14720};
    wr(8'h00, 32'h8);
    cfg(8'h50, 4'h6);
    cfg(8'h54, 4'h7);
    cfg(8'h58, 4'h8);
    cfg(8'h5c, 4'h9);
    cfg(8'h60, 4'h7);
    cfg(8'h64, 4'h7);
    cfg(8'h68, 4'h8);
    wait_lock(16'h01f3);
    repeat (1100) @(posedge clk_i);
    chk(lock, 16'h01f3);
    rrl_host_i.xfer(1'b0, 8'h04, 32'h0, q);
    chk(q, 32'h0604_01f3);
    $display("t_rates done");
  endtask
  task t_rst;
    wr(8'h00, 32'h3);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(lock, 16'h0000);
    chk({pgen, pchk}, 32'h0);
    rd(8'h00, 32'h8);
    rd(8'h50, 32'h1);
    rd(8'h04, 32'h0);
    $display("t_rst done");
  endtask
  task finish_test;
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    n_mismatch++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reg;
    t_excl;
    t_lock;
    t_rates;
    t_rst;
    finish_test;
  end
endmodule // retimer_rate_lock_setup_bench
`default_nettype wire
